// File: common/psw_pkg.sv
// Package of constants for the status word and bank select block
package psw_pkg;
    // ------------------------------------------------------------
    // Status word layout
    // ------------------------------------------------------------
    localparam int PSW_W          = 8;
    localparam int CARRY_BIT      = 7;
    localparam int AUX_BIT        = 6;
    localparam int USER_BIT       = 5;
    localparam int BANK_HI_BIT    = 4;
    localparam int BANK_LO_BIT    = 3;
    localparam int OVF_BIT        = 2;
    localparam int RSVD_BIT       = 1;
    localparam int PARITY_BIT     = 0;
    localparam logic [7:0] PSW_RESET = 8'h00;  // All flags clear, bank 0
    localparam logic [7:0] SW_MASK   = 8'hFD;  // Reserved bit not stored
    localparam int BANK_SIZE_LOG2 = 3;         // Eight bytes per bank
    // ------------------------------------------------------------
    // APB register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] PSW_OFFSET  = 8'h00; // Status word
    localparam logic [7:0] ACC_OFFSET  = 8'h04; // Accumulator view, read only
    localparam logic [7:0] BASE_OFFSET = 8'h08; // Active bank base, read only
endpackage

// File: src/psw_flag_calc.sv
// Flag arithmetic: parity, overflow, carries of an add or subtract
`timescale 1ns/1ps
`default_nettype none
module psw_flag_calc (
    input  wire logic [7:0] acc,        // Current accumulator
    input  wire logic [7:0] opa,        // First operand
    input  wire logic [7:0] opb,        // Second operand
    input  wire logic       cin,        // Carry or borrow in
    input  wire logic       sub,        // High for subtract
    output logic            parity,     // Odd count of ones
    output logic            carry,      // Carry or borrow out of bit 7
    output logic            aux_carry,  // Carry or borrow out of bit 3
    output logic            overflow    // Signed overflow
);
    logic [8:0] full_sum;  // Nine-bit result
    logic [4:0] low_sum;   // Low nibble result
    logic [7:0] opb_eff;   // Operand after subtract inversion
    logic       cin_eff;   // Carry in after inversion

    // Parity: reduction xor gives odd-ones flag
    assign parity  = ^acc;
    // Subtract done as add of complement; borrow is inverted carry
    assign opb_eff = sub ? ~opb : opb;
    assign cin_eff = sub ? ~cin : cin;
    assign full_sum = {1'b0, opa} + {1'b0, opb_eff} + {8'h00, cin_eff};
    assign low_sum  = {1'b0, opa[3:0]} + {1'b0, opb_eff[3:0]} + {4'h0, cin_eff};
    assign carry     = full_sum[8] ^ sub;
    assign aux_carry = low_sum[4] ^ sub;
    // Signed overflow: operands agree in sign, result differs
    assign overflow  = (opa[7] == opb_eff[7]) && (full_sum[7] != opa[7]);
endmodule
`default_nettype wire

// File: src/psw_bank_select.sv
// Status word with flag update, bank select and APB access
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module psw_bank_select
    import psw_pkg::*;
(
    input  wire logic        pclk,           // Core clock
    input  wire logic        presetn,        // Async reset, active low
    input  wire logic        psel,           // APB select
    input  wire logic        penable,        // APB access phase
    input  wire logic        pwrite,         // APB direction
    input  wire logic [7:0]  paddr,          // APB byte address
    input  wire logic [31:0] pwdata,         // APB write data
    output logic [31:0]      prdata,         // APB read data
    output logic             pready,         // APB ready
    output logic             pslverr,        // APB error
    input  wire logic        instr_cycle,    // One pulse per instruction cycle
    input  wire logic [7:0]  acc_value,      // Accumulator contents
    input  wire logic        alu_update,     // Arithmetic result strobe
    input  wire logic        alu_sub,        // Subtract when high
    input  wire logic        alu_use_carry,  // Carry in from carry flag
    input  wire logic [7:0]  alu_opa,        // First operand
    input  wire logic [7:0]  alu_opb,        // Second operand
    input  wire logic        core_wr,        // Core byte write of status word
    input  wire logic [7:0]  core_wdata,     // Core write data
    input  wire logic [2:0]  reg_index,      // Register operand number
    output logic [7:0]       program_status_word, // Status word view
    output logic [4:0]       reg_ram_addr,   // RAM address of register operand
    output logic [1:0]       bank_select     // Active bank
);
    import psw_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] psw_q;        // Stored status word
    logic       parity_q;     // Parity flag
    logic       calc_par;     // Parity of accumulator now
    logic       calc_cy;      // Computed carry
    logic       calc_ac;      // Computed aux carry
    logic       calc_ov;      // Computed overflow
    logic       apb_wr;       // APB write this edge
    logic [7:0] psw_view;     // Assembled status word

    assign apb_wr = psel && penable && pwrite && (paddr == PSW_OFFSET);

    psw_flag_calc u_calc (
        .acc       (acc_value),
        .opa       (alu_opa),
        .opb       (alu_opb),
        .cin       (alu_use_carry & psw_q[CARRY_BIT]),
        .sub       (alu_sub),
        .parity    (calc_par),
        .carry     (calc_cy),
        .aux_carry (calc_ac),
        .overflow  (calc_ov)
    );

    // ------------------------------------------------------------
    // Stored flags: writes win over arithmetic; both need full byte
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psw_q <= PSW_RESET;
        end else if (apb_wr) begin
            // Byte lands except the masked reserved bit, carry included
            psw_q <= pwdata[7:0] & SW_MASK;
        end else if (core_wr) begin
            // Core logic op on the word updates every flag but parity
            psw_q <= core_wdata & SW_MASK;
        end else if (alu_update) begin
            psw_q[CARRY_BIT] <= calc_cy;
            psw_q[AUX_BIT]   <= calc_ac;
            psw_q[OVF_BIT]   <= calc_ov;
        end
    end

    // ------------------------------------------------------------
    // Parity: hardware-owned, refreshed each instruction cycle
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            parity_q <= 1'b0;
        end else if (instr_cycle) begin
            parity_q <= calc_par;
        end
    end

    // Reserved bit reads zero; parity written by software is ignored
    always_comb begin
        psw_view = psw_q;
        psw_view[RSVD_BIT]   = 1'b0;
        psw_view[PARITY_BIT] = parity_q;
    end

    // ------------------------------------------------------------
    // Outputs registered; bank change seen on the next cycle
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_status_word <= PSW_RESET;
            bank_select         <= 2'h0;
            reg_ram_addr        <= 5'h00;
        end else begin
            program_status_word <= psw_view;
            bank_select  <= {psw_q[BANK_HI_BIT], psw_q[BANK_LO_BIT]};
            // Bank number times eight plus register number
            reg_ram_addr <= {psw_q[BANK_HI_BIT], psw_q[BANK_LO_BIT], reg_index};
        end
    end

    // ------------------------------------------------------------
    // APB slave: zero wait, unmapped reads zero with error
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                case (paddr)
                    PSW_OFFSET:  prdata <= {24'h000000, psw_view};
                    ACC_OFFSET:  prdata <= {24'h000000, acc_value};
                    BASE_OFFSET: prdata <= {27'h0, psw_q[BANK_HI_BIT],
                                            psw_q[BANK_LO_BIT], 3'h0};
                    default:     pslverr <= 1'b1;
                endcase
                if (pwrite && (paddr == ACC_OFFSET || paddr == BASE_OFFSET)) begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks: flag arithmetic and parity
    // ------------------------------------------------------------
    // All checks share the core clock and its reset
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Parity strobe lands the accumulator parity one edge later
    parity_refresh_a: assert property (
        instr_cycle |=> psw_view[PARITY_BIT] == ^$past(acc_value))
        else $error("parity stale");

    // Accumulator plus flag always even after a refresh
    parity_even_a: assert property (
        instr_cycle |=> ^{$past(acc_value), parity_q} == 1'b0)
        else $error("parity not even");

    // Parity only moves on the strobe, never on writes
    parity_hold_a: assert property (
        !instr_cycle |=> parity_q == $past(parity_q))
        else $error("parity moved");

    // Overflow follows the signed result of the operation
    overflow_set_a: assert property (
        alu_update && !apb_wr && !core_wr |=> psw_q[OVF_BIT] == $past(calc_ov))
        else $error("overflow wrong");

    // Aux carry follows the low nibble carry or borrow
    aux_carry_a: assert property (
        alu_update && !apb_wr && !core_wr |=> psw_q[AUX_BIT] == $past(calc_ac))
        else $error("aux carry wrong");

    // Carry follows bit 7 carry or borrow
    carry_set_a: assert property (
        alu_update && !apb_wr && !core_wr |=> psw_q[CARRY_BIT] == $past(calc_cy))
        else $error("carry wrong");

    // ------------------------------------------------------------
    // Checks: bank select and byte writes
    // ------------------------------------------------------------
    // Register address is bank times eight plus index
    bank_addr_a: assert property (
        1'b1 |=> reg_ram_addr ==
        {$past(psw_q[BANK_HI_BIT]), $past(psw_q[BANK_LO_BIT]), $past(reg_index)})
        else $error("bank map wrong");

    // New bank visible two edges after the write
    bank_follow_a: assert property (
        apb_wr |=> ##1 bank_select ==
        {$past(pwdata[BANK_HI_BIT], 2), $past(pwdata[BANK_LO_BIT], 2)})
        else $error("bank select late");

    // Reserved position never reads as one
    reserved_zero_a: assert property (
        program_status_word[RSVD_BIT] == 1'b0)
        else $error("reserved bit set");

    // Software byte write replaces every stored flag
    byte_write_a: assert property (
        apb_wr |=> psw_q == ($past(pwdata[7:0]) & SW_MASK))
        else $error("byte write lost");

    // Core byte write replaces every stored flag too
    core_write_a: assert property (
        core_wr && !apb_wr |=> psw_q == ($past(core_wdata) & SW_MASK))
        else $error("core write lost");

    // Status word view trails the assembled word by one edge
    psw_view_a: assert property (
        1'b1 |=> program_status_word == $past(psw_view))
        else $error("view stale");

    // ------------------------------------------------------------
    // Checks: bus handshake
    // ------------------------------------------------------------
    // Zero wait: ready in the access cycle
    apb_ready_a: assert property (
        psel && !penable |=> pready)
        else $error("no ready");

    // Ready stands for a single cycle
    ready_pulse_a: assert property (
        pready |=> !pready)
        else $error("ready stuck");

    // Error is only reported together with ready
    slverr_ready_a: assert property (
        pslverr |-> pready)
        else $error("error without ready");

    // ------------------------------------------------------------
    // Scenario coverage
    // ------------------------------------------------------------
    // Highest bank reached
    bank3_c: cover property (bank_select == 2'h3);
    // Overflow produced by arithmetic
    ovf_c: cover property (alu_update ##1 psw_q[OVF_BIT]);
    // Odd accumulator seen
    parity_c: cover property (instr_cycle ##1 parity_q);
    // Core byte write path used
    core_write_c: cover property (core_wr && !apb_wr);
    // Subtract with borrow out
    borrow_c: cover property (alu_update && alu_sub ##1 psw_q[CARRY_BIT]);
endmodule
`default_nettype wire

// File: test/psw_core_model.sv
// Core sequencer stand-in: free-running instruction-cycle strobe
`timescale 1ns/1ps
`default_nettype none
module psw_core_model #(
    parameter int PERIOD = 3   // Clocks per instruction cycle
) (
    input  wire logic pclk,         // Core clock
    input  wire logic presetn,      // Async reset, active low
    output logic      instr_cycle   // One pulse per instruction
);
    int cnt_q;  // Position inside the instruction
    // Strobe once per PERIOD; quiet in reset so nothing races release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q       <= 0;
            instr_cycle <= 1'b0;
        end else begin
            cnt_q       <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
            instr_cycle <= (cnt_q == PERIOD - 1);
        end
    end
endmodule
`default_nettype wire

// File: test/psw_bank_select_tb.sv
// Self-checking bench for the status word and bank select block
`timescale 1ns/1ps
`default_nettype none
module psw_bank_select_tb;
    import psw_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        instr_cycle, alu_update, alu_sub, alu_use_carry, core_wr;
    logic [7:0]  paddr, acc_value, alu_opa, alu_opb, core_wdata, psw_view;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  reg_index;
    logic [4:0]  ram_addr;
    logic [1:0]  bank;
    int          n_mismatch, tests_run, cyc, ep, a, b, c, r;
    psw_bank_select uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instr_cycle(instr_cycle), .acc_value(acc_value),
        .alu_update(alu_update), .alu_sub(alu_sub), .alu_use_carry(alu_use_carry),
        .alu_opa(alu_opa), .alu_opb(alu_opb), .core_wr(core_wr), .core_wdata(core_wdata),
        .reg_index(reg_index), .program_status_word(psw_view), .reg_ram_addr(ram_addr),
        .bank_select(bank));
    psw_core_model core (.pclk(pclk), .presetn(presetn), .instr_cycle(instr_cycle));
    // -----------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // One APB transfer; pready is sampled before the edge's updates land
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tally_and_finish;
        if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // -----------------------------------------------------------
    // Clock and hang guard
    // -----------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 5000) begin
            n_mismatch++;
            tally_and_finish;
        end
    end
    // -----------------------------------------------------------
    // Main sequence; ep is the reference status word
    // -----------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, alu_update, alu_sub, alu_use_carry, core_wr} = '0;
        {paddr, acc_value, alu_opa, alu_opb, core_wdata, pwdata, reg_index} = '0;
        void'($urandom(61048));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        ep = 0;
        apb(1'b0, PSW_OFFSET, 0);
        chk(ep, rd);
        for (int i = 0; i < 8; i++) begin
            acc_value <= 8'($urandom);
            repeat (8) @(posedge pclk);
            ep[0] = ^acc_value;
            chk(ep, psw_view);
        end
        // Arithmetic: every mix of add/subtract and carry-in
        for (int i = 0; i < 24; i++) begin
            a = $urandom_range(255);
            b = $urandom_range(255);
            alu_opa <= a[7:0];
            alu_opb <= b[7:0];
            alu_sub <= i[0];
            alu_use_carry <= i[1];
            alu_update <= 1'b1;
            @(posedge pclk);
            alu_update <= 1'b0;
            c = i[1] ? ep[7] : 0;
            r = i[0] ? a - b - c : a + b + c;
            ep[6] = i[0] ? ((a % 16) < (b % 16) + c) : ((a % 16) + (b % 16) + c > 15);
            ep[7] = r[8];
            ep[2] = (a[7] == (b[7] ^ i[0])) && (r[7] != a[7]);
            repeat (3) @(posedge pclk);
            chk(ep, psw_view);
        end
        // Byte writes from software and core, all four banks
        for (int i = 0; i < 8; i++) begin
            a = $urandom_range(255);
            a[4:3] = i[1:0];
            reg_index <= 3'($urandom);
            if (i[2]) begin
                core_wr <= 1'b1;
                core_wdata <= a[7:0];
                @(posedge pclk);
                core_wr <= 1'b0;
            end else apb(1'b1, PSW_OFFSET, a);
            ep = (a & 'hFC) | ep[0];
            repeat (3) @(posedge pclk);
            apb(1'b0, PSW_OFFSET, 0);
            chk(ep, rd);
            chk(i[1:0], bank);
            chk({i[1:0], reg_index}, ram_addr);
            apb(1'b0, BASE_OFFSET, 0);
            chk(i[1:0] * 8, rd);
        end
        // Accumulator view reads back; unmapped reads and read-only writes are refused
        apb(1'b0, ACC_OFFSET, 0);
        chk(acc_value, rd);
        apb(1'b0, 8'h0C, 0);
        chk(1, err);
        apb(1'b1, ACC_OFFSET, 'hFF);
        chk(1, err);
        tally_and_finish;
    end
endmodule
`default_nettype wire
